// ==== logic/posns_pkg.sv ====
// Purpose: shared constants for the port power and overcurrent sense block
// Assumes: 250 MHz core clock, byte-wide register port
// Notes:   offsets are the register port addresses as printed
package posns_pkg;

	localparam int NPORTS = 6;
	localparam int ADDR_W = 16;
	localparam int DATA_W = 8;

	////////////////////////////////////////////////////////////////////////////
	// register offsets
	localparam logic [15:0] OFS_POWER_ON_IGNORE_TIME = 16'h30E1;
	localparam logic [15:0] OFS_MIN_PULSE_WIDTH      = 16'h30EA;
	localparam logic [15:0] OFS_REPEAT_PULSE_WINDOW  = 16'h30EB;
	localparam logic [15:0] OFS_PORT_POWER_CTL       = 16'h30F0;
	localparam logic [15:0] OFS_PORT_MODE            = 16'h30F1;
	localparam logic [15:0] OFS_OC_STATUS            = 16'h30F2;

	////////////////////////////////////////////////////////////////////////////
	// reset values and fields
	localparam logic [7:0] RST_POWER_ON_IGNORE_TIME = 8'h0A;
	localparam logic [3:0] RST_MIN_PULSE_WIDTH      = 4'h5;
	localparam logic [7:0] RST_REPEAT_PULSE_WINDOW  = 8'h14;
	localparam logic [5:0] RST_PORT_POWER_CTL       = 6'h00;
	localparam logic       RST_GANG_MODE            = 1'b0;
	localparam int         MIN_WIDTH_MSB            = 3;
	localparam int         GANG_MODE_BIT            = 0;

	////////////////////////////////////////////////////////////////////////////
	// timing
	localparam int CLK_PERIOD_NS  = 4;
	localparam int TICK_PERIOD_MS = 1;
	localparam int TICK_CYCLES    = (TICK_PERIOD_MS * 1000000) / CLK_PERIOD_NS;

	typedef enum logic [1:0] {
		ST_OFF,
		ST_LOCKOUT,
		ST_WATCH
	} posns_state_e;

	// one step down per millisecond tick, stopping at zero
	function automatic logic [7:0] tick_down(input logic [7:0] cnt, input logic tick);
		tick_down = (tick && cnt != 8'h00) ? cnt - 8'h01 : cnt;
	endfunction

endpackage

// ==== logic/posns_port.sv ====
// Purpose: one power/sense pin: drive, lockout and overcurrent filter
// Assumes: sense input synchronous to core_clk, tick one cycle per ms
// Notes:   emits a one-cycle pulse per overcurrent sample; flags live above
`timescale 1ns/1ps
module posns_port (
	// clock and reset
	input  wire logic       core_clk,
	input  wire logic       rst,
	// control
	input  wire logic       tick,
	input  wire logic       power_on,
	input  wire logic [7:0] lockout_ms,
	input  wire logic [3:0] min_width_ms,
	input  wire logic [7:0] window_ms,
	// pin
	input  wire logic       pin_in,
	output logic            pin_out,
	output logic            pin_oe_n,
	output logic            pullup_en,
	// detection
	output logic            oc_pulse
);

	posns_pkg::posns_state_e state_reg, state_next;
	logic [7:0] lock_reg,   lock_next;
	logic [3:0] run_reg,    run_next;
	logic [7:0] win_reg,    win_next;
	logic       prev_low_reg;

	wire logic sense_low   = ~pin_in;
	// pin sampled every cycle in watch
	wire logic watching    = (state_reg == posns_pkg::ST_WATCH);
	wire logic group_end   = prev_low_reg & ~sense_low;
	wire logic single_hit  = watching & sense_low & (run_reg >= min_width_ms);
	wire logic double_hit  = watching & sense_low & ~prev_low_reg & (win_reg != 8'h00);

	////////////////////////////////////////////////////////////////////////////
	// sequencing
	always_comb begin
		state_next = state_reg;
		lock_next  = lock_reg;
		unique case (state_reg)
			posns_pkg::ST_OFF: begin
				if (power_on) begin
					state_next = posns_pkg::ST_LOCKOUT;
					lock_next  = lockout_ms;
				end
			end
			posns_pkg::ST_LOCKOUT: begin
				// count lockout in ms, ignore pin
				lock_next = posns_pkg::tick_down(lock_reg, tick);
				if (!power_on)
					state_next = posns_pkg::ST_OFF;
				else if (lock_reg == 8'h00)
					state_next = posns_pkg::ST_WATCH;
			end
			posns_pkg::ST_WATCH: begin
				if (!power_on)
					state_next = posns_pkg::ST_OFF;
			end
		endcase
	end

	// low run measured in ms ticks, saturating
	assign run_next = (!watching || !sense_low) ? 4'h0 :
		((tick && run_reg != 4'hF) ? run_reg + 4'h1 : run_reg);
	// window reloads at the end of each low group
	assign win_next = !watching ? 8'h00 :
		(group_end ? window_ms : posns_pkg::tick_down(win_reg, tick));

	always_ff @(posedge core_clk or posedge rst) begin
		if (rst) begin
			state_reg    <= posns_pkg::ST_OFF;
			lock_reg     <= 8'h00;
			run_reg      <= 4'h0;
			win_reg      <= 8'h00;
			prev_low_reg <= 1'b0;
			oc_pulse     <= 1'b0;
			pin_out      <= 1'b0;
			pin_oe_n     <= 1'b0;
			pullup_en    <= 1'b0;
		end else begin
			state_reg    <= state_next;
			lock_reg     <= lock_next;
			run_reg      <= run_next;
			win_reg      <= win_next;
			prev_low_reg <= watching & sense_low;
			oc_pulse     <= single_hit | double_hit;
			pin_out      <= 1'b0;
			pin_oe_n     <= power_on;
			pullup_en    <= power_on;
		end
	end

endmodule

// ==== logic/posns_top.sv ====
// Purpose: downstream port power control and overcurrent sensing
// Assumes: inputs synchronous to core_clk, software avoids zero timers
// Notes:   one detector per port plus one for the shared ganged pin
`timescale 1ns/1ps
module posns_top #(
	parameter int unsigned TICK_CYCLES = posns_pkg::TICK_CYCLES
) (
	// clock and reset
	input  wire logic        core_clk,
	input  wire logic        rst,
	// register port
	input  wire logic [15:0] reg_addr,
	input  wire logic [7:0]  reg_wdata,
	input  wire logic        reg_wr,
	input  wire logic        reg_rd,
	output logic      [7:0]  reg_rdata,
	// hub port logic
	input  wire logic [5:0]  oc_clear,
	output logic      [5:0]  oc_status,
	// per-port power/sense pins
	input  wire logic [5:0]  port_power_sense_pin_in,
	output logic      [5:0]  port_power_sense_pin_out,
	output logic      [5:0]  port_power_sense_pin_oe_n,
	output logic      [5:0]  port_power_sense_pullup_en,
	// shared ganged pin
	input  wire logic        shared_power_pin_in,
	output logic             shared_power_pin_out,
	output logic             shared_power_pin_oe_n,
	output logic             shared_power_pullup_en
);

	localparam int NP = posns_pkg::NPORTS;

	logic [7:0]  lockout_reg;
	logic [3:0]  min_width_reg;
	logic [7:0]  window_reg;
	logic [5:0]  power_ctl_reg;
	logic        gang_reg;
	logic [5:0]  oc_next;
	logic [7:0]  rdata_next;
	logic [17:0] tick_cnt_reg;
	logic        tick_reg;
	logic [5:0]  port_oc;
	logic        gang_oc;

	////////////////////////////////////////////////////////////////////////////
	// millisecond timebase
	localparam logic [17:0] TICK_LAST = 18'(TICK_CYCLES - 1);

	always_ff @(posedge core_clk or posedge rst) begin
		if (rst) begin
			tick_cnt_reg <= 18'h00000;
			tick_reg     <= 1'b0;
		end else begin
			tick_cnt_reg <= (tick_cnt_reg == TICK_LAST) ? 18'h00000 : tick_cnt_reg + 18'h00001;
			tick_reg     <= (tick_cnt_reg == TICK_LAST);
		end
	end

	////////////////////////////////////////////////////////////////////////////
	// register decode
	// one strobe qualified by one register offset
	function automatic logic reg_hit(input logic strobe, input logic [15:0] addr,
		input logic [15:0] ofs);
		reg_hit = strobe & (addr == ofs);
	endfunction

	wire logic wr_lockout = reg_hit(reg_wr, reg_addr, posns_pkg::OFS_POWER_ON_IGNORE_TIME);
	wire logic wr_width   = reg_hit(reg_wr, reg_addr, posns_pkg::OFS_MIN_PULSE_WIDTH);
	wire logic wr_window  = reg_hit(reg_wr, reg_addr, posns_pkg::OFS_REPEAT_PULSE_WINDOW);
	wire logic wr_power   = reg_hit(reg_wr, reg_addr, posns_pkg::OFS_PORT_POWER_CTL);
	wire logic wr_mode    = reg_hit(reg_wr, reg_addr, posns_pkg::OFS_PORT_MODE);
	wire logic wr_status  = reg_hit(reg_wr, reg_addr, posns_pkg::OFS_OC_STATUS);

	wire logic [5:0] sw_clear = wr_status ? reg_wdata[5:0] : 6'h00;

	// shared pin overcurrent hits every port
	wire logic [5:0] oc_set   = gang_reg ? {NP{gang_oc}} : port_oc;
	// flags that survive this cycle's clears
	wire logic [5:0] oc_hold  = oc_status & ~(oc_clear | sw_clear);
	// sticky flag, set wins over clear
	assign oc_next = oc_set | oc_hold;

	always_comb begin
		rdata_next = 8'h00;
		if (reg_rd) begin
			unique case (reg_addr)
				posns_pkg::OFS_POWER_ON_IGNORE_TIME: rdata_next = lockout_reg;
				posns_pkg::OFS_MIN_PULSE_WIDTH:      rdata_next = {4'h0, min_width_reg};
				posns_pkg::OFS_REPEAT_PULSE_WINDOW:  rdata_next = window_reg;
				posns_pkg::OFS_PORT_POWER_CTL:       rdata_next = {2'b00, power_ctl_reg};
				posns_pkg::OFS_PORT_MODE:            rdata_next = {7'h00, gang_reg};
				posns_pkg::OFS_OC_STATUS:            rdata_next = {2'b00, oc_status};
				default:                             rdata_next = 8'h00;
			endcase
		end
	end

	////////////////////////////////////////////////////////////////////////////
	// register storage
	// one short process per register keeps each write decode local

	always_ff @(posedge core_clk or posedge rst) begin
		if (rst) begin
			lockout_reg <= posns_pkg::RST_POWER_ON_IGNORE_TIME;
		end else if (wr_lockout) begin
			lockout_reg <= reg_wdata;
		end
	end

	always_ff @(posedge core_clk or posedge rst) begin
		if (rst) begin
			min_width_reg <= posns_pkg::RST_MIN_PULSE_WIDTH;
		end else if (wr_width) begin
			min_width_reg <= reg_wdata[posns_pkg::MIN_WIDTH_MSB:0];
		end
	end

	always_ff @(posedge core_clk or posedge rst) begin
		if (rst) begin
			window_reg <= posns_pkg::RST_REPEAT_PULSE_WINDOW;
		end else if (wr_window) begin
			window_reg <= reg_wdata;
		end
	end

	// bit i powers port i in individual mode; in ganged mode any set bit powers the shared pin
	always_ff @(posedge core_clk or posedge rst) begin
		if (rst) begin
			power_ctl_reg <= posns_pkg::RST_PORT_POWER_CTL;
		end else if (wr_power) begin
			power_ctl_reg <= reg_wdata[5:0];
		end
	end

	// mode may change while powered; detectors restart their lockout
	always_ff @(posedge core_clk or posedge rst) begin
		if (rst) begin
			gang_reg <= posns_pkg::RST_GANG_MODE;
		end else if (wr_mode) begin
			gang_reg <= reg_wdata[posns_pkg::GANG_MODE_BIT];
		end
	end

	// flags follow the set-wins next value
	always_ff @(posedge core_clk or posedge rst) begin
		if (rst) begin
			oc_status <= 6'h00;
		end else begin
			oc_status <= oc_next;
		end
	end

	// read data stand one cycle, zero otherwise
	always_ff @(posedge core_clk or posedge rst) begin
		if (rst) begin
			reg_rdata <= 8'h00;
		end else begin
			reg_rdata <= rdata_next;
		end
	end

	////////////////////////////////////////////////////////////////////////////
	// detectors
	// individual pins sit unpowered in ganged mode so they never report
	wire logic [5:0] indiv_on = gang_reg ? 6'h00 : power_ctl_reg;
	// ganged supply is on when any port asks for power
	wire logic       gang_on  = gang_reg & (|power_ctl_reg);

	genvar gi;
	generate
		for (gi = 0; gi < NP; gi++) begin : g_port
			posns_port u_port (
				.core_clk     (core_clk),
				.rst          (rst),
				.tick         (tick_reg),
				.power_on     (indiv_on[gi]),
				.lockout_ms   (lockout_reg),
				.min_width_ms (min_width_reg),
				.window_ms    (window_reg),
				.pin_in       (port_power_sense_pin_in[gi]),
				.pin_out      (port_power_sense_pin_out[gi]),
				.pin_oe_n     (port_power_sense_pin_oe_n[gi]),
				.pullup_en    (port_power_sense_pullup_en[gi]),
				.oc_pulse     (port_oc[gi])
			);
		end
	endgenerate

	// single shared pin in ganged mode
	posns_port u_gang (
		.core_clk     (core_clk),
		.rst          (rst),
		.tick         (tick_reg),
		.power_on     (gang_on),
		.lockout_ms   (lockout_reg),
		.min_width_ms (min_width_reg),
		.window_ms    (window_reg),
		.pin_in       (shared_power_pin_in),
		.pin_out      (shared_power_pin_out),
		.pin_oe_n     (shared_power_pin_oe_n),
		.pullup_en    (shared_power_pullup_en),
		.oc_pulse     (gang_oc)
	);

endmodule

// ==== bench/posns_top_monitor.sv ====
// Purpose: port-level checks of the power/sense block
// Assumes: one clock domain, bound to posns_top
// Notes:   sees only top ports
`timescale 1ns/1ps
module posns_top_monitor #(
	parameter int unsigned TICK_CYCLES = 10
) (
	// clock and reset
	input wire logic        core_clk,
	input wire logic        rst,
	// register port
	input wire logic [15:0] reg_addr,
	input wire logic [7:0]  reg_wdata,
	input wire logic        reg_wr,
	input wire logic        reg_rd,
	input wire logic [7:0]  reg_rdata,
	// hub port logic
	input wire logic [5:0]  oc_clear,
	input wire logic [5:0]  oc_status,
	// pins
	input wire logic [5:0]  port_power_sense_pin_in,
	input wire logic [5:0]  port_power_sense_pin_out,
	input wire logic [5:0]  port_power_sense_pin_oe_n,
	input wire logic [5:0]  port_power_sense_pullup_en,
	input wire logic        shared_power_pin_in,
	input wire logic        shared_power_pin_out,
	input wire logic        shared_power_pin_oe_n,
	input wire logic        shared_power_pullup_en
);
	wire logic [5:0] w1c = {6{reg_wr && reg_addr == posns_pkg::OFS_OC_STATUS}} & reg_wdata[5:0];
	wire logic [5:0] clr_any = oc_clear | w1c;
	wire logic [5:0] rel = port_power_sense_pin_oe_n | {6{shared_power_pin_oe_n}};
	// leaving gang mode also hands power back to the single pins
	wire logic       ctl_wr = reg_wr && (reg_addr == posns_pkg::OFS_PORT_POWER_CTL
		|| reg_addr == posns_pkg::OFS_PORT_MODE);
	wire logic       mapped = reg_addr inside {16'h30E1, 16'h30EA, 16'h30EB, 16'h30F0, 16'h30F1,
		16'h30F2};
	default clocking cb @(posedge core_clk); endclocking
	default disable iff (rst);
	a_pullup_follows: assert property (
		port_power_sense_pullup_en == port_power_sense_pin_oe_n
		&& shared_power_pullup_en == shared_power_pin_oe_n) else $error("pullup mismatch");
	a_drive_only_low: assert property (
		port_power_sense_pin_out == 6'h00 && !shared_power_pin_out)
		else $error("pin driven high");
	a_rdata_idle: assert property (!$past(reg_rd) |-> reg_rdata == 8'h00)
		else $error("read data outside slot");
	a_width_reserved: assert property (
		$past(reg_rd) && $past(reg_addr) == posns_pkg::OFS_MIN_PULSE_WIDTH
		|-> reg_rdata[7:4] == 4'h0) else $error("reserved width bits set");
	a_unmapped_zero: assert property ($past(reg_rd) && !$past(mapped) |-> reg_rdata == 8'h00)
		else $error("unmapped read nonzero");
	a_power_delay: assert property (
		|(port_power_sense_pin_oe_n & ~$past(port_power_sense_pin_oe_n)) |-> $past(ctl_wr, 2))
		else $error("release without power write");
	a_status_sticky: assert property (
		!(|($past(oc_status) & ~oc_status & ~$past(clr_any))))
		else $error("status dropped");
	a_oc_powered: assert property (
		|(oc_status & ~$past(oc_status)) |-> ((oc_status & ~$past(oc_status))
		& ~($past(rel, 2) & $past(rel, 4))) == 6'h00)
		else $error("flag while unpowered");
	a_gang_idle: assert property (
		shared_power_pin_oe_n |-> port_power_sense_pin_oe_n == 6'h00)
		else $error("individual pin released in gang");
	c_flag: cover property (|(oc_status & ~$past(oc_status)));
	c_gang_all: cover property (oc_status == 6'h3F);
	c_clear: cover property (|oc_clear ##1 oc_status == 6'h00);
endmodule
bind posns_top posns_top_monitor #(.TICK_CYCLES(TICK_CYCLES)) i_mon (.core_clk(core_clk),
	.rst(rst), .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd),
	.reg_rdata(reg_rdata), .oc_clear(oc_clear), .oc_status(oc_status),
	.port_power_sense_pin_in(port_power_sense_pin_in),
	.port_power_sense_pin_out(port_power_sense_pin_out),
	.port_power_sense_pin_oe_n(port_power_sense_pin_oe_n),
	.port_power_sense_pullup_en(port_power_sense_pullup_en),
	.shared_power_pin_in(shared_power_pin_in), .shared_power_pin_out(shared_power_pin_out),
	.shared_power_pin_oe_n(shared_power_pin_oe_n), .shared_power_pullup_en(shared_power_pullup_en));

// ==== bench/posns_switch_model.sv ====
// Purpose: external power switch / fuse seen at the pins
// Assumes: fault high pulls the sense node low
// Notes:   an unpulled released pin wanders
`timescale 1ns/1ps
module posns_switch_model (
	// clock
	input  wire logic       core_clk,
	// device side
	input  wire logic [6:0] drv,
	input  wire logic [6:0] oe_n,
	input  wire logic [6:0] pull,
	// fault control
	input  wire logic [6:0] fault,
	// pin level
	output logic      [6:0] pin
);
	logic alt = 1'b0;
	always @(posedge core_clk) alt <= ~alt;
	// fuse boards report power good at once, so no ramp is modelled
	assign pin = (~oe_n & drv) | (oe_n & pull & ~fault) | (oe_n & ~pull & {7{alt}});
endmodule

// ==== bench/test_posns_top.sv ====
// Purpose: scenario bench for posns_top
// Assumes: TICK_CYCLES 10, so 1 ms is 10 cycles
// Notes:   faults come from the switch model
`timescale 1ns/1ps
module test_posns_top;
	logic        core_clk = 1'b0;
	logic        rst = 1'b1;
	logic [15:0] a = 16'h0000;
	logic [7:0]  wd = 8'h00;
	logic        wr = 1'b0;
	logic        rd = 1'b0;
	logic [5:0]  clr = 6'h00;
	logic [6:0]  fault = 7'h00;
	logic [7:0]  rdata;
	logic [5:0]  oc;
	wire [6:0]   drv, oe_n, pull, pin;
	int          mismatches = 0;
	int          tests_run = 0;
	always #2 core_clk = ~core_clk;
	posns_top #(.TICK_CYCLES(10)) i_dut (.core_clk(core_clk), .rst(rst), .reg_addr(a),
		.reg_wdata(wd), .reg_wr(wr), .reg_rd(rd), .reg_rdata(rdata), .oc_clear(clr),
		.oc_status(oc), .port_power_sense_pin_in(pin[5:0]), .port_power_sense_pin_out(drv[5:0]),
		.port_power_sense_pin_oe_n(oe_n[5:0]), .port_power_sense_pullup_en(pull[5:0]),
		.shared_power_pin_in(pin[6]), .shared_power_pin_out(drv[6]),
		.shared_power_pin_oe_n(oe_n[6]), .shared_power_pullup_en(pull[6]));
	posns_switch_model i_sw (.core_clk(core_clk), .drv(drv), .oe_n(oe_n), .pull(pull),
		.fault(fault), .pin(pin));
	task automatic chk(string name, logic [7:0] exp, logic [7:0] got);
		tests_run++;
		if (got !== exp) begin
			$display("CHECK FAILED %s expected %h seen %h", name, exp, got);
			mismatches++;
		end
	endtask
	task automatic w(logic [15:0] ad, logic [7:0] d);
		@(posedge core_clk) {wr, a, wd} <= {1'b1, ad, d};
		@(posedge core_clk) wr <= 1'b0;
	endtask
	task automatic rc(logic [15:0] ad, logic [7:0] exp, string name);
		@(posedge core_clk) {rd, a} <= {1'b1, ad};
		@(posedge core_clk) rd <= 1'b0;
		#1 chk(name, exp, rdata);
	endtask
	task automatic cyc(int n);
		repeat (n) @(posedge core_clk);
		#1;
	endtask
	task automatic wt(logic [5:0] exp, int n);
		while (oc !== exp && n > 0) begin
			cyc(1);
			n--;
		end
		chk("oc_wait", {2'b00, exp}, {2'b00, oc});
		if (oc !== exp) complete_run();
	endtask
	task automatic t_regs;
		rc(16'h30E1, 8'h0A, "lockout_rst");
		rc(16'h30EA, 8'h05, "width_rst");
		rc(16'h30EB, 8'h14, "window_rst");
		w(16'h30EA, 8'hFF);
		rc(16'h30EA, 8'h0F, "width_rsvd");
		rc(16'h3000, 8'h00, "unmapped");
	endtask
	task automatic t_pins;
		w(16'h30F0, 8'h3F);
		cyc(3);
		chk("oe_on", 8'h3F, {1'b0, oe_n});
		chk("pull_on", 8'h3F, {1'b0, pull});
		w(16'h30F0, 8'h00);
		cyc(3);
		chk("oe_off", 8'h00, {1'b0, oe_n | pull | drv});
	endtask
	task automatic t_lock;
		w(16'h30E1, 8'h03);
		w(16'h30EA, 8'h00);
		fault <= 7'h01;
		w(16'h30F0, 8'h01);
		cyc(18);
		chk("in_lockout", 8'h00, {2'b00, oc});
		wt(6'h01, 40);
		fault <= 7'h00;
		cyc(5);
		chk("sticky", 8'h01, {2'b00, oc});
		w(16'h30F2, 8'h01);
		#1 chk("w1c", 8'h00, {2'b00, oc});
	endtask
	task automatic t_single;
		w(16'h30F0, 8'h00);
		w(16'h30EA, 8'h02);
		w(16'h30EB, 8'h01);
		// re-power: the power-off above already dropped the window left by the last low group
		w(16'h30F0, 8'h01);
		cyc(45);
		fault <= 7'h01;
		cyc(5);
		fault <= 7'h00;
		cyc(25);
		chk("short_low", 8'h00, {2'b00, oc});
		fault <= 7'h01;
		wt(6'h01, 40);
		fault <= 7'h00;
		w(16'h30F2, 8'h01);
	endtask
	task automatic t_double;
		w(16'h30EA, 8'h05);
		w(16'h30EB, 8'h14);
		cyc(30);
		fault <= 7'h01;
		cyc(3);
		fault <= 7'h00;
		cyc(30);
		chk("first_group", 8'h00, {2'b00, oc});
		fault <= 7'h01;
		cyc(3);
		fault <= 7'h00;
		wt(6'h01, 10);
		@(posedge core_clk) clr <= 6'h01;
		@(posedge core_clk) clr <= 6'h00;
		cyc(1);
		chk("clear_in", 8'h00, {2'b00, oc});
		w(16'h30F0, 8'h00);
	endtask
	task automatic t_gang;
		w(16'h30F1, 8'h01);
		w(16'h30F0, 8'h01);
		cyc(3);
		chk("gang_pins", 8'h40, {1'b0, oe_n});
		cyc(40);
		fault <= 7'h40;
		wt(6'h3F, 60);
		fault <= 7'h00;
		w(16'h30F0, 8'h00);
		w(16'h30F2, 8'h3F);
		#1 chk("gang_clear", 8'h00, {2'b00, oc});
		w(16'h30F1, 8'h00);
	endtask
	task automatic complete_run;
		$display("comparisons %0d mismatches %0d", tests_run, mismatches);
		if (mismatches == 0 && tests_run > 0) begin
			$display("[ PASS ]");
		end else begin
			$display("[ FAIL ]");
		end
		$finish;
	endtask
	initial begin
		cyc(3);
		rst <= 1'b0;
		t_regs();
		t_pins();
		t_lock();
		t_single();
		t_double();
		t_gang();
		complete_run();
	end
endmodule
